// file: core/adc_link_pkg.sv
package adc_link_pkg;
  // Result and address widths
  localparam int RESULT_W = 10;
  localparam int ADDR_W = 4;
  // Serial frame: four address clocks, ten shift clocks in all
  localparam int ADDR_CLOCKS = 4;
  localparam int FRAME_CLOCKS = 10;
  // Conversion length in conversion-clock cycles
  localparam int CONV_CYCLES = 44;
  // Select recognition: two rising then one falling conversion edge
  localparam int SEL_RISES = 2;
  // Channel number of the internal test source
  localparam logic [3:0] SELF_TEST_CHANNEL = 4'hb;
  localparam int NUM_CHANNELS = 11;
  // Host link clock divider: half period in system cycles
  localparam int LINK_HALF_DIV = 6;
  // Conversion clock divider on the device side, half period in cycles
  localparam int CONV_HALF_DIV = 4;
  // Reset value of the held result
  localparam logic [9:0] RESULT_RST = 10'h000;
  // Buffer depth for results on the host side
  localparam int FIFO_DEPTH = 16;
endpackage : adc_link_pkg

// file: core/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
  // Select, active low, driven by the host
  logic sel_n;
  // Address bit from the host
  logic addr_in;
  // Shift clock from the host
  logic shift_clk;
  // Three-state data out: value and enable, enable low drives
  logic data_o;
  logic data_oe_n;
  // Resolved line seen by the host
  logic data_line;
  assign data_line = data_oe_n ? 1'b0 : data_o;
  modport device (input sel_n, input addr_in, input shift_clk,
                  output data_o, output data_oe_n);
  modport host (output sel_n, output addr_in, output shift_clk,
                input data_line);
endinterface : adc_link_if

// file: core/result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage has no reset, only pointers do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : result_fifo

// file: core/adc_device_end.sv
`timescale 1ns/1ps
// Operation
// - Select high: output released, inputs ignored
// - Select recognised after two rises, one fall
// - Recognised select drives previous result MSB
// - Four address bits, MSB first, rising edges
// - First four falls shift result bits two-five
// - Sampling starts after fourth falling edge
// - Falls five to nine shift bits six-ten
// - Tenth fall holds, then 44 conversion cycles
// - Host keeps clock low or select high
// - Recognised select fall aborts conversion
// - New sequence aborts; old result kept
// - Host keeps shift clock free of glitches
// - Shared clock: shift when low, convert high
// - No address shift during select recognition
// - Shared clock: host raises select after tenth
// - Sampling continues until tenth falling edge
// - Shift and conversion clocks independent unless strapped shared
// - Channel eleven is internal test source
module adc_device_end #(
  parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Conversion clock pin and shared-clock strap
  input wire logic conv_clk,
  input wire logic shared_clk,
  // Link to the host
  adc_link_if.device link,
  // Analog stand-in: converted code of the selected channel
  input wire logic [9:0] analog_code,
  input wire logic [9:0] self_test_code,
  // Status
  output logic [3:0] mux_addr,
  output logic sampling,
  output logic converting,
  output logic [9:0] result
);
  logic [2:0] sel_s_q;
  logic [2:0] sck_s_q;
  logic [2:0] cck_s_q;
  logic [1:0] addr_s_q;
  logic sel_n_s;
  logic [1:0] shared_s_q;
  logic shared_s;
  logic sck_rise;
  logic sck_fall;
  logic cck_pin_rise;
  logic cck_pin_fall;
  logic cck_rise;
  logic cck_fall;
  logic [1:0] rise_cnt_q;
  logic sel_ok_q;
  logic [3:0] clk_cnt_q;
  logic [3:0] addr_sh_q;
  logic [9:0] shift_q;
  logic [9:0] sample_q;
  logic [5:0] conv_cnt_q;
  logic sh_rise;
  logic sh_fall;
  logic conv_tick;
  logic sel_ok_p_q;
  logic sel_recog;

  // Edge finder on a synchroniser chain: {rise, fall} of stage 2 vs 3
  function automatic logic [1:0] edges_of(input logic [2:0] chain);
    edges_of = {chain[1] && !chain[2], !chain[1] && chain[2]};
  endfunction : edges_of

  // Pins cross into clk through two flops; stage 2 vs 3 finds edges
  // The strap is a pin too, so it is synchronised like the others
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_s_q <= 3'h7;
      sck_s_q <= 3'h0;
      cck_s_q <= 3'h0;
      addr_s_q <= 2'h0;
      shared_s_q <= 2'h0;
    end else begin
      sel_s_q <= {sel_s_q[1:0], link.sel_n};
      sck_s_q <= {sck_s_q[1:0], link.shift_clk};
      cck_s_q <= {cck_s_q[1:0], conv_clk};
      addr_s_q <= {addr_s_q[0], link.addr_in};
      shared_s_q <= {shared_s_q[0], shared_clk};
    end
  end

  assign sel_n_s = sel_s_q[1];
  assign shared_s = shared_s_q[1];
  assign {sck_rise, sck_fall} = edges_of(sck_s_q);
  assign {cck_pin_rise, cck_pin_fall} = edges_of(cck_s_q);
  // Shared mode takes the conversion edges from the shift pin
  assign cck_rise = shared_s ? sck_rise : cck_pin_rise;
  assign cck_fall = shared_s ? sck_fall : cck_pin_fall;
  // Shift clock acts only once select is recognised
  assign sh_rise = sel_ok_q && sck_rise;
  assign sh_fall = sel_ok_q && sck_fall;
  // Conversion runs while select is not recognised low in shared mode;
  // a shared clock therefore cannot convert during a held-low frame
  assign conv_tick = cck_rise && !(shared_s && sel_ok_q);

  // Select filter: two conversion rises then a fall after the low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rise_cnt_q <= 2'h0;
      sel_ok_q <= 1'b0;
    end else if (sel_n_s) begin
      rise_cnt_q <= 2'h0;
      sel_ok_q <= 1'b0;
    end else if (!sel_ok_q) begin
      // Count stops at two rises; only a fall after them recognises
      if (cck_rise && rise_cnt_q != 2'(adc_link_pkg::SEL_RISES)) begin
        rise_cnt_q <= rise_cnt_q + 2'h1;
      end else if (cck_fall &&
                   rise_cnt_q == 2'(adc_link_pkg::SEL_RISES)) begin
        sel_ok_q <= 1'b1;
      end
    end
  end

  // Recognition pulse; a noise dip on select never aborts a conversion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_ok_p_q <= 1'b0;
    end else begin
      sel_ok_p_q <= sel_ok_q;
    end
  end

  // Recognised select fall, the only select event that aborts a conversion
  assign sel_recog = sel_ok_q && !sel_ok_p_q;

  // Frame counter, address shift and result shift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_cnt_q <= 4'h0;
      addr_sh_q <= 4'h0;
      shift_q <= adc_link_pkg::RESULT_RST;
      mux_addr <= 4'h0;
      sampling <= 1'b0;
    end else if (!sel_ok_q) begin
      clk_cnt_q <= 4'h0;
      sampling <= 1'b0; // A cut frame leaves no sampling behind
      shift_q <= result; // MSB waits on the pin at recognition
    end else begin
      if (sh_rise && clk_cnt_q < 4'(adc_link_pkg::ADDR_CLOCKS)) begin
        addr_sh_q <= {addr_sh_q[2:0], addr_s_q[1]};
      end
      // Mux address changes once, whole, never bit by bit
      if (sh_fall) begin
        shift_q <= {shift_q[8:0], 1'b0};
        if (clk_cnt_q == 4'(adc_link_pkg::ADDR_CLOCKS - 1)) begin
          mux_addr <= addr_sh_q;
          sampling <= 1'b1;
        end
        if (clk_cnt_q == 4'(adc_link_pkg::FRAME_CLOCKS - 1)) begin
          sampling <= 1'b0; // hold instant
          clk_cnt_q <= 4'h0; // Ready for the next frame under low select
          shift_q <= result;
        end else begin
          clk_cnt_q <= clk_cnt_q + 4'h1;
        end
      end
    end
  end

  // Sample the selected channel, then convert over 44 ticks
  // An aborted conversion leaves the old result standing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_q <= adc_link_pkg::RESULT_RST;
      conv_cnt_q <= 6'h0;
      converting <= 1'b0;
      result <= adc_link_pkg::RESULT_RST;
    end else if (sel_recog && converting) begin
      converting <= 1'b0; // abort; a new frame also aborts
    end else if (sh_fall &&
                 clk_cnt_q == 4'(adc_link_pkg::FRAME_CLOCKS - 1)) begin
      // Hold instant is the tenth fall, so a strobed host picks it
      // test source on its own channel
      sample_q <= (addr_sh_q == adc_link_pkg::SELF_TEST_CHANNEL) ?
                  self_test_code : analog_code;
      conv_cnt_q <= 6'h0;
      converting <= 1'b1;
    end else if (converting && conv_tick) begin
      if (conv_cnt_q == 6'(CONV_CYCLES - 1)) begin
        converting <= 1'b0;
        result <= sample_q;
      end else begin
        conv_cnt_q <= conv_cnt_q + 6'h1;
      end
    end
  end

  // Data pin: released unless select recognised
  // Registered so the pin never glitches while select resolves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.data_oe_n <= 1'b1;
      link.data_o <= 1'b0;
    end else begin
      link.data_oe_n <= !sel_ok_q || sel_n_s;
      link.data_o <= shift_q[9];
    end
  end
endmodule : adc_device_end

// file: core/adc_host_end.sv
`timescale 1ns/1ps
module adc_host_end #(
  parameter int WAIT_CYCLES = 48 * adc_link_pkg::LINK_HALF_DIV * 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request a conversion on a channel
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_chan,
  // Previous result with the channel sent in that frame
  output logic res_valid,
  input wire logic res_ready,
  output logic [13:0] res_data,
  // Link
  adc_link_if.host link
);
  typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_WAIT} st_t;
  st_t st_q;
  logic [1:0] dline_q;
  logic [3:0] chan_q;
  logic [3:0] bit_q;
  logic [9:0] rx_q;
  logic [11:0] div_q;
  logic [11:0] wait_q;
  logic push;
  logic fifo_ready;
  logic [13:0] push_data;

  // Data line is from the device's domain: two flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dline_q <= 2'h0;
    end else begin
      dline_q <= {dline_q[0], link.data_line};
    end
  end

  // Frame sequencer; back-pressure holds off new frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      link.sel_n <= 1'b1;
      link.shift_clk <= 1'b0;
      link.addr_in <= 1'b0;
      chan_q <= 4'h0;
      bit_q <= 4'h0;
      rx_q <= 10'h0;
      div_q <= 12'h0;
      wait_q <= 12'h0;
      push <= 1'b0;
      push_data <= 14'h0;
      req_ready <= 1'b0;
    end else begin
      push <= 1'b0;
      req_ready <= (st_q == ST_IDLE) && fifo_ready && !req_valid;
      case (st_q)
        ST_IDLE: begin
          if (req_valid && fifo_ready) begin
            chan_q <= req_chan;
            link.sel_n <= 1'b0;
            div_q <= 12'(WAIT_CYCLES / 8); // Let select be recognised
            st_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (div_q == 12'h0) begin
            bit_q <= 4'h0;
            link.addr_in <= chan_q[3]; // MSB first
            rx_q <= {9'h0, dline_q[1]};
            div_q <= 12'(adc_link_pkg::LINK_HALF_DIV);
            st_q <= ST_LOW;
          end else begin
            div_q <= div_q - 12'h1;
          end
        end
        ST_LOW: begin
          if (div_q == 12'h0) begin
            link.shift_clk <= 1'b1;
            div_q <= 12'(adc_link_pkg::LINK_HALF_DIV);
            st_q <= ST_HIGH;
          end else begin
            div_q <= div_q - 12'h1;
          end
        end
        ST_HIGH: begin
          if (div_q == 12'h0) begin
            link.shift_clk <= 1'b0;
            div_q <= 12'(adc_link_pkg::LINK_HALF_DIV);
            bit_q <= bit_q + 4'h1;
            if (bit_q < 4'h3) begin
              link.addr_in <= chan_q[2'(2 - bit_q)];
            end
            if (bit_q == 4'(adc_link_pkg::FRAME_CLOCKS - 1)) begin
              wait_q <= 12'(WAIT_CYCLES);
              st_q <= ST_WAIT;
            end else begin
              st_q <= ST_LOW;
            end
          end else begin
            div_q <= div_q - 12'h1;
            // Open a slot for the bit that the coming fall brings
            if (div_q == 12'h1 &&
                bit_q != 4'(adc_link_pkg::FRAME_CLOCKS - 1)) begin
              rx_q <= {rx_q[8:0], 1'b0};
            end
          end
        end
        ST_WAIT: begin
          link.sel_n <= 1'b1; // held high through conversion
          if (wait_q == 12'h0) begin
            st_q <= ST_IDLE;
          end else begin
            wait_q <= wait_q - 12'h1;
            if (wait_q == 12'(WAIT_CYCLES)) begin
              push <= 1'b1;
              push_data <= {chan_q, rx_q};
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      // Capture as the low half ends: a fall reaches the line only after
      // the pin synchronisers and the output flop of both ends
      if (st_q == ST_LOW && div_q == 12'h0 && bit_q != 4'h0) begin
        rx_q[0] <= dline_q[1];
      end
    end
  end

  // Result buffer; a full buffer stops new frames
  result_fifo #(
    .WIDTH(14),
    .DEPTH(adc_link_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule : adc_host_end

// file: sim/adc_link_monitor.sv
`timescale 1ns/1ps
module adc_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic sel_n,
  input wire logic addr_in,
  input wire logic shift_clk,
  input wire logic data_o,
  input wire logic data_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] since_q;
  logic [3:0] rises_q;
  // Age of the last shift fall; saturates so a stray data change is caught
  always_ff @(posedge clk or posedge rst) begin
    if (rst) since_q <= 8'hff;
    else if ($fell(shift_clk)) since_q <= 8'h00;
    else if (since_q != 8'hff) since_q <= since_q + 8'h01;
  end
  // Shift rises seen in the current frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rises_q <= 4'h0;
    else if ($fell(sel_n)) rises_q <= 4'h0;
    else if ($rose(shift_clk)) rises_q <= rises_q + 4'h1;
  end
  sequence sel_fall_s;
    $fell(sel_n);
  endsequence
  sequence sel_rise_s;
    $rose(sel_n);
  endsequence
  oe_idle_a: assert property (sel_n [*6] |-> data_oe_n)
    else $error("data driven while deselected");
  oe_release_a: assert property (sel_rise_s |-> ##[1:6] data_oe_n)
    else $error("data not released after deselect");
  filter_min_a: assert property (sel_fall_s |-> data_oe_n [*8])
    else $error("select taken before filter");
  filter_max_a: assert property (
    sel_fall_s |-> ##[1:48] (!data_oe_n || sel_n))
    else $error("select never recognised");
  data_step_a: assert property (
    !data_oe_n && $past(data_oe_n) == 1'b0 && $changed(data_o)
    |-> since_q <= 8'h08)
    else $error("data changed without shift fall");
  clk_framed_a: assert property (
    $rose(shift_clk) |-> !sel_n && rises_q < 4'ha)
    else $error("shift clock outside frame");
  frame_len_a: assert property (sel_rise_s |-> rises_q == 4'ha)
    else $error("frame not ten clocks");
  addr_setup_a: assert property ($rose(shift_clk) |-> $stable(addr_in))
    else $error("address moved at shift rise");
endmodule : adc_link_monitor

// file: sim/serial_adc_control_sequencer_tb.sv
`timescale 1ns/1ps
module serial_adc_control_sequencer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic conv_clk = 1'b0;
  logic req_valid = 1'b0;
  logic [3:0] req_chan = 4'h0;
  logic res_ready = 1'b0;
  logic drain_en = 1'b0;
  logic [9:0] analog_code = 10'h000;
  logic [9:0] self_test_code = 10'h000;
  logic req_ready, res_valid, sampling, converting;
  logic sck_q = 1'b0;
  logic [13:0] res_data;
  logic [3:0] mux_addr;
  logic [3:0] last_ch = 4'h0;
  logic [3:0] addr_sh = 4'h0;
  logic [3:0] rise_n = 4'h0;
  logic [9:0] result;
  logic [9:0] prev_q = adc_link_pkg::RESULT_RST;
  logic [9:0] corner [4] = '{10'h3ff, 10'h000, 10'h2aa, 10'h155};
  logic [13:0] exp_q [$];
  int n_fail = 0;
  int n_checks = 0;
  int k;
  bit ok;
  adc_link_if link_if ();
  adc_device_end u_adc_device_end (.clk(clk), .rst(rst),
    .conv_clk(conv_clk), .shared_clk(1'b0), .link(link_if.device),
    .analog_code(analog_code), .self_test_code(self_test_code),
    .mux_addr(mux_addr), .sampling(sampling), .converting(converting),
    .result(result));
  adc_host_end u_adc_host_end (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_chan(req_chan),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .link(link_if.host));
  adc_link_monitor u_adc_link_monitor (.clk(clk), .rst(rst),
    .sel_n(link_if.sel_n), .addr_in(link_if.addr_in),
    .shift_clk(link_if.shift_clk), .data_o(link_if.data_o),
    .data_oe_n(link_if.data_oe_n));
  // System clock
  always #2 clk = ~clk;
  // Conversion clock, offset so its edges never meet clk
  initial begin
    #1.3;
    forever #24 conv_clk = ~conv_clk;
  end
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic must(input bit good);
    check({13'h0000, good}, 14'h0001);
    if (!good) close_out();
  endtask : must
  // Code the converter should hold after sampling channel ch
  function automatic logic [9:0] exp_code(input logic [3:0] ch,
                                          input logic [9:0] a);
    return (ch == adc_link_pkg::SELF_TEST_CHANNEL) ? ~a : a;
  endfunction : exp_code
  // One conversion request; inputs stay put until the next one is taken
  task automatic send(input logic [3:0] ch, input logic [9:0] a,
                      input int lim, output bit good);
    int i;
    for (i = 0; i < lim && req_ready !== 1'b1; i++) @(posedge clk);
    good = (i < lim);
    if (good) begin
      check({6'h00, addr_sh, mux_addr}, {6'h00, last_ch, last_ch});
      check({2'b00, sampling, converting, result}, {4'h0, prev_q});
      req_valid <= 1'b1;
      req_chan <= ch;
      analog_code <= a;
      self_test_code <= ~a;
      exp_q.push_back({ch, prev_q});
      prev_q = exp_code(ch, a);
      last_ch = ch;
      @(posedge clk);
      req_valid <= 1'b0;
      @(posedge clk);
    end
  endtask : send
  task automatic wait_empty(input int lim);
    int i;
    for (i = 0; i < lim && exp_q.size() != 0; i++) @(posedge clk);
    must(exp_q.size() == 0);
  endtask : wait_empty
  // Wire watcher for address bits; drain side with random stalls
  always @(posedge clk) begin
    sck_q <= link_if.shift_clk;
    res_ready <= drain_en && ($urandom_range(3) != 0);
    if (link_if.sel_n) rise_n <= 4'h0;
    else if (link_if.shift_clk && !sck_q) begin
      rise_n <= rise_n + 4'h1;
      if (rise_n < 4'h4) addr_sh <= {addr_sh[2:0], link_if.addr_in};
      check({13'h0000, sampling}, {13'h0000, rise_n >= 4'h4});
    end
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      check({13'h0000, exp_q.size() == 0}, 14'h0000);
      if (exp_q.size() != 0) begin
        check(res_data, exp_q.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(32'ha094d43d));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Every channel, corner codes first, buffer not drained
    for (k = 0; k < adc_link_pkg::FIFO_DEPTH; k++) begin
      send(4'(k % 12), (k < 4) ? corner[k] : 10'($urandom), 20000, ok);
      must(ok);
    end
    $display("test fill done");
    // Full buffer refuses a further request
    send(4'h1, 10'h0f0, 4000, ok);
    check({13'h0000, ok}, 14'h0000);
    $display("test refuse done");
    drain_en <= 1'b1;
    wait_empty(20000);
    $display("test drain done");
    // Random channels and codes under random stalls
    for (k = 0; k < 8; k++) begin
      send(4'($urandom_range(11)), 10'($urandom), 20000, ok);
      must(ok);
    end
    wait_empty(20000);
    // Last conversion has no later frame to report it: look directly
    repeat (adc_link_pkg::CONV_CYCLES * 16) @(posedge clk);
    check({2'b00, sampling, converting, result}, {4'h0, prev_q});
    $display("test random done");
    close_out();
  end
endmodule : serial_adc_control_sequencer_tb
